// file: logic/shared_period_pwm_channels.sv
// Shared-period PWM channels with a classic Wishbone register slave
// What this block does
// R1 - Each channel duty value is ten bits: eight high plus two low.
// R2 - All channels share one period; each keeps its own duty value.
// R3 - No postscaler is involved in output generation or frequency.
// R4 - Enabled outputs go active when the shared counter clears at rollover.
// R5 - Output goes inactive when the 10-bit time base equals buffered duty.
// R6 - Duty beyond the period never matches, so the output stays full on.
// R7 - Duty registers are double buffered and reload only at period match.
// R8 - After counter equals period: clear, set outputs unless 0%, reload.
// R9 - Software writes both duty halves before the next period match.
// R10 - Period is (period+1) times four clocks times the prescale value.
// R11 - Time base is counter plus two prescaled clock-phase bits below it.
// R12 - Duty writes at any time leave the running waveform undisturbed.
// R13 - Only period 255 gives all 1024 duty steps; smaller gives fewer.
// R14 - In sleep the counter stops, channel state and pin level hold.
// R15 - Reset releases all pins and returns every register to reset value.
// R16 - Control bit 7 enables the channel; it resets to zero.
// R17 - Control bit 6 routes the channel to its pin, else pin released.
// R18 - Control bit 5 reads the current output level; writes are ignored.
// R19 - Control bit 4 set makes the output active low.
// R20 - Control bits 3 to 0 read zero and ignore writes.
// R21 - Software follows the setup order to get a complete first pulse.
// R22 - Software sets pin direction to output before the pin shows PWM.
// R23 - Duty high register holds the eight upper bits, read and write.
// R24 - Duty low holds two lower bits at 7:6; bits 5:0 read zero.
// R25 - Counter advances per clock/4/prescale, only while timer runs.
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module shared_period_pwm_channels (
    input  wire logic                        clk_i,   // System clock
    input  wire logic                        rst_i,   // Sync reset, high
    input  wire logic [7:0]                  adr_i,   // Byte address
    input  wire logic [31:0]                 dat_i,   // Write data
    input  wire logic                        we_i,    // Write strobe
    input  wire logic [3:0]                  sel_i,   // Byte lanes
    input  wire logic                        cyc_i,   // Bus cycle
    input  wire logic                        stb_i,   // Strobe
    output logic      [31:0]                 dat_o,   // Read data
    output logic                             ack_o,   // Acknowledge
    input  wire logic                        sleep_i, // Core in sleep
    output logic      [pwm_pkg::NUM_CH-1:0]  pin_level_o, // Pin levels
    output logic      [pwm_pkg::NUM_CH-1:0]  pin_oe_o     // Pin drive on
);

    // ========================================================
    // Declarations
    logic [7:0]         period_reg;
    pwm_pkg::tctrl_t    tctrl_reg;
    logic [7:0]         count_reg;
    logic [1:0]         phase_reg;
    logic [5:0]         ps_cnt_reg;
    logic [5:0]         ps_last;
    logic               tick_en;
    logic               phase_step;
    logic               count_step;
    logic               rollover;
    logic [9:0]         timebase;
    logic [9:0]         timebase_next;
    logic               ack_reg;
    logic [31:0]        dat_reg;
    logic [7:0]         rdata;
    logic               req;
    logic               wr_fire;

    pwm_pkg::ch_ctrl_t  ctrl_reg   [pwm_pkg::NUM_CH];
    pwm_pkg::duty_t     duty_reg   [pwm_pkg::NUM_CH];
    pwm_pkg::duty_t     duty_buf   [pwm_pkg::NUM_CH];
    logic               out_reg    [pwm_pkg::NUM_CH];
    logic [pwm_pkg::NUM_CH-1:0] level_reg;
    logic [pwm_pkg::NUM_CH-1:0] oe_reg;

    // ========================================================
    // Decode helpers
    // Channel blocks sit 16 bytes apart, three word registers each
    function automatic logic ch_hit(input logic [7:0] adr,
                                    input int ch);
        logic [3:0] blk;
        blk = pwm_pkg::CH_BLOCK_FIRST + 4'(ch);
        return adr[7:4] == blk;
    endfunction

    function automatic logic [5:0] prescale_last(input logic [1:0] sel);
        unique case (sel)
            pwm_pkg::PS_SEL_1:  prescale_last = pwm_pkg::PS_LAST_1;
            pwm_pkg::PS_SEL_4:  prescale_last = pwm_pkg::PS_LAST_4;
            pwm_pkg::PS_SEL_16: prescale_last = pwm_pkg::PS_LAST_16;
            default:            prescale_last = pwm_pkg::PS_LAST_64;
        endcase
    endfunction

    // ========================================================
    // Wishbone slave
    assign req     = cyc_i & stb_i;
    // Write lands at the edge the master sees ack high;
    // read data was caught one edge earlier, so it stands with ack
    assign wr_fire = req & ack_reg & we_i & sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (req & ~ack_reg) begin
            dat_reg <= {24'h00_0000, rdata};
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // Unmapped addresses read as zero and still acknowledge
    always_comb begin
        // Unimplemented bits keep this zero
        rdata = 8'h00;
        if (adr_i == pwm_pkg::ADR_PERIOD) begin
            rdata = period_reg;
        end else if (adr_i == pwm_pkg::ADR_TCTRL) begin
            rdata[pwm_pkg::TRUN_BIT] = tctrl_reg.run;
            rdata[1:0]               = tctrl_reg.ps;
        end else if (adr_i == pwm_pkg::ADR_COUNT) begin
            rdata = count_reg;
        end
        for (int c = 0; c < pwm_pkg::NUM_CH; c++) begin
            if (ch_hit(adr_i, c)) begin
                case (adr_i[3:2])
                    pwm_pkg::SUB_CTRL: begin
                        rdata[pwm_pkg::EN_BIT]  = ctrl_reg[c].en;    // [R16]
                        rdata[pwm_pkg::OE_BIT]  = ctrl_reg[c].oe;    // [R17]
                        rdata[pwm_pkg::OUT_BIT] = level_reg[c];      // [R18]
                        rdata[pwm_pkg::POL_BIT] = ctrl_reg[c].pol;   // [R19]
                    end
                    pwm_pkg::SUB_DUTY_HI: begin
                        rdata = duty_reg[c].high;                    // [R23]
                    end
                    pwm_pkg::SUB_DUTY_LO: begin
                        rdata[pwm_pkg::DUTY_LO_MSB:pwm_pkg::DUTY_LO_LSB] =
                            duty_reg[c].low;                         // [R24]
                    end
                    default: begin
                        rdata = 8'h00;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // Shared timer registers
    // The counter reads back only; a write to it is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_reg <= pwm_pkg::PERIOD_RST;                       // [R15]
            tctrl_reg  <= '0;
        end else if (wr_fire) begin
            if (adr_i == pwm_pkg::ADR_PERIOD) begin
                period_reg <= dat_i[7:0];
            end
            if (adr_i == pwm_pkg::ADR_TCTRL) begin
                tctrl_reg.run <= dat_i[pwm_pkg::TRUN_BIT];
                tctrl_reg.ps  <= dat_i[1:0];
            end
        end
    end

    // ========================================================
    // Time base: prescaler, clock phase, shared counter
    // No postscaler exists here; the period depends only on these three
    assign ps_last    = prescale_last(tctrl_reg.ps);                 // [R3]
    assign tick_en    = tctrl_reg.run & ~sleep_i;                    // [R25] [R14]
    // >= so a smaller prescale taken mid-count steps at once
    assign phase_step = tick_en & (ps_cnt_reg >= ps_last);           // [R11]
    assign count_step = phase_step & (phase_reg == pwm_pkg::PHASE_LAST);
    assign rollover   = count_step & (count_reg == period_reg);      // [R8] [R10]
    assign timebase   = {count_reg, phase_reg};                      // [R11] [R13]
    // The value the next phase step reaches; compares use it so a
    // match drops the output as the time base arrives, not a clock late
    assign timebase_next = timebase + 10'h001;                       // [R5]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ps_cnt_reg <= '0;
        end else if (phase_step) begin
            ps_cnt_reg <= '0;
        end else if (tick_en) begin
            ps_cnt_reg <= ps_cnt_reg + 6'h01;                        // [R25]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= '0;
        end else if (phase_step) begin
            phase_reg <= phase_reg + 2'h1;                           // [R11]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= pwm_pkg::COUNT_RST;
        end else if (rollover) begin
            count_reg <= pwm_pkg::COUNT_RST;                         // [R8]
        end else if (count_step) begin
            count_reg <= count_reg + 8'h01;                          // [R2]
        end
    end

    // ========================================================
    // Channels
    // All checks run on the one clock and stand down during reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    generate
        for (genvar c = 0; c < pwm_pkg::NUM_CH; c++) begin : g_ch

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ctrl_reg[c] <= '0;                               // [R15] [R16]
                end else if (wr_fire && ch_hit(adr_i, c) &&
                             adr_i[3:2] == pwm_pkg::SUB_CTRL) begin
                    // Status bit and low nibble are not stored
                    ctrl_reg[c].en  <= dat_i[pwm_pkg::EN_BIT];       // [R16] [R18]
                    ctrl_reg[c].oe  <= dat_i[pwm_pkg::OE_BIT];       // [R17]
                    ctrl_reg[c].pol <= dat_i[pwm_pkg::POL_BIT];      // [R19] [R20]
                end
            end

            // Software copy; the waveform sees the buffer, plus a zero test of this copy at rollover
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    duty_reg[c] <= '0;
                end else if (wr_fire && ch_hit(adr_i, c)) begin
                    if (adr_i[3:2] == pwm_pkg::SUB_DUTY_HI) begin
                        duty_reg[c].high <= dat_i[7:0];              // [R1] [R23] [R12]
                    end
                    if (adr_i[3:2] == pwm_pkg::SUB_DUTY_LO) begin
                        duty_reg[c].low <= dat_i[pwm_pkg::DUTY_LO_MSB:
                                                 pwm_pkg::DUTY_LO_LSB]; // [R24] [R9]
                    end
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    duty_buf[c] <= '0;
                end else if (rollover) begin
                    duty_buf[c] <= duty_reg[c];                      // [R7] [R8]
                end
            end

            // Equality compare: a duty past the last time base step
            // never matches, which yields full duty without a compare;
            // only phase steps and a cleared enable bit clear, so sleep and a stopped timer hold
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    out_reg[c] <= 1'b0;
                end else if (!ctrl_reg[c].en) begin
                    out_reg[c] <= 1'b0;                              // [R16]
                end else if (rollover) begin
                    out_reg[c] <= (duty_reg[c] != '0);               // [R4] [R8]
                end else if (phase_step && timebase_next == duty_buf[c]) begin
                    out_reg[c] <= 1'b0;                              // [R5] [R6]
                end
            end

            // Pin stage; pin also holds in sleep because out_reg holds
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    level_reg[c] <= 1'b0;
                    oe_reg[c]    <= 1'b0;                            // [R15]
                end else begin
                    level_reg[c] <= out_reg[c] ^ ctrl_reg[c].pol;    // [R19] [R14]
                    oe_reg[c]    <= ctrl_reg[c].oe;                  // [R17] [R22]
                end
            end

            // ================================================
            // Checks
            AST_SET_AT_ROLL: assert property (                       // [R4]
                rollover && ctrl_reg[c].en && duty_reg[c] != '0
                |=> out_reg[c] ##1 level_reg[c] == !ctrl_reg[c].pol)
                else $error("output not active after rollover");

            AST_CLEAR_AT_MATCH: assert property (                    // [R5]
                ctrl_reg[c].en && !rollover && phase_step &&
                timebase_next == duty_buf[c] |=> !out_reg[c])
                else $error("output not cleared at duty match");

            AST_BUF_RELOAD: assert property (                        // [R7]
                rollover |=> duty_buf[c] == $past(duty_reg[c]))
                else $error("duty buffer not reloaded at rollover");

            AST_BUF_HOLD: assert property (                          // [R12]
                !rollover |=> $stable(duty_buf[c]))
                else $error("duty buffer changed between rollovers");

            AST_DISABLED_LOW: assert property (                      // [R16]
                !ctrl_reg[c].en |=> !out_reg[c] ##1
                level_reg[c] == $past(ctrl_reg[c].pol))
                else $error("disabled channel not inactive");

            AST_PIN_ROUTE: assert property (                         // [R17]
                ##1 oe_reg[c] == $past(ctrl_reg[c].oe))
                else $error("pin drive does not follow route bit");

            AST_ZERO_DUTY: assert property (                         // [R8]
                rollover && duty_reg[c] == '0 |=> !out_reg[c][*3])
                else $error("zero duty produced a pulse");

            AST_PULSE_WIDTH: assert property (                       // [R5]
                rollover && !req && ctrl_reg[c].en && !sleep_i &&
                tctrl_reg.ps == pwm_pkg::PS_SEL_1 &&
                duty_reg[c] == 10'h002 |=> out_reg[c][*2] ##1 !out_reg[c])
                else $error("two-step duty gave a wrong pulse width");

            AST_FULL_DUTY: assert property (                         // [R6]
                ctrl_reg[c].en && out_reg[c] && !rollover &&
                count_reg <= period_reg &&
                duty_buf[c] > {period_reg, pwm_pkg::PHASE_LAST}
                |=> out_reg[c])
                else $error("full duty channel driven inactive");

            COV_PULSE: cover property (
                rollover ##1 out_reg[c] ##[1:1000] !out_reg[c]);
            COV_FULL: cover property (
                rollover && ctrl_reg[c].en ##1 out_reg[c][*8]);
        end
    endgenerate

    AST_ACK_ONE: assert property (
        ack_reg |=> !ack_reg)
        else $error("ack held longer than one cycle");

    AST_ACK_NEXT: assert property (
        req && !ack_reg |=> ack_reg)
        else $error("ack not given the cycle after request");

    AST_ROLL_CLEAR: assert property (                                // [R8]
        rollover |=> count_reg == pwm_pkg::COUNT_RST && phase_reg == '0)
        else $error("counter not cleared on rollover");

    AST_MIN_PERIOD: assert property (                                // [R10]
        rollover |=> !rollover[*3])
        else $error("period shorter than four clocks");

    AST_PHASE_CARRY: assert property (                               // [R11]
        count_step |=> phase_reg == '0)
        else $error("phase did not wrap on a counter step");

    AST_COUNT_STEP: assert property (                                // [R10]
        count_step && !rollover |=> count_reg == $past(count_reg) + 8'h01)
        else $error("counter did not advance by one");

    AST_SLEEP_HOLD: assert property (                                // [R14]
        sleep_i |=> $stable(count_reg) && $stable(phase_reg))
        else $error("time base moved in sleep");

    AST_STOP_HOLD: assert property (                                 // [R25]
        !tctrl_reg.run |=> $stable(count_reg) && $stable(ps_cnt_reg))
        else $error("time base moved while timer off");

    COV_ROLL: cover property (rollover ##[4:1000] rollover);
    COV_WRITE: cover property (wr_fire ##[1:1000] rollover);
    COV_SLEEP: cover property (tctrl_reg.run && sleep_i ##1 sleep_i[*8]);

    assign pin_level_o = level_reg;
    assign pin_oe_o    = oe_reg;

endmodule

`default_nettype wire

// file: logic/pwm_pkg.sv
// Constants, register map and carrier types of the shared-period PWM block
`default_nettype none
package pwm_pkg;

    // ========================================================
    // Structure
    localparam int          NUM_CH        = 4;
    localparam int          CLK_HZ        = 20_000_000;

    // ========================================================
    // Register map (byte addresses)
    localparam logic [7:0]  ADR_PERIOD    = 8'h00;
    localparam logic [7:0]  ADR_TCTRL     = 8'h04;
    localparam logic [7:0]  ADR_COUNT     = 8'h08;
    localparam logic [3:0]  CH_BLOCK_FIRST = 4'h1;
    localparam logic [1:0]  SUB_CTRL      = 2'h0;
    localparam logic [1:0]  SUB_DUTY_HI   = 2'h1;
    localparam logic [1:0]  SUB_DUTY_LO   = 2'h2;

    // ========================================================
    // Field positions
    localparam int          EN_BIT        = 7;
    localparam int          OE_BIT        = 6;
    localparam int          OUT_BIT       = 5;
    localparam int          POL_BIT       = 4;
    localparam int          TRUN_BIT      = 2;
    localparam int          DUTY_LO_MSB   = 7;
    localparam int          DUTY_LO_LSB   = 6;

    // ========================================================
    // Reset values
    localparam logic [7:0]  PERIOD_RST    = 8'hFF;
    localparam logic [7:0]  COUNT_RST     = 8'h00;

    // ========================================================
    // Prescaler: last count of the divider for each select code
    localparam logic [1:0]  PS_SEL_1      = 2'h0;
    localparam logic [1:0]  PS_SEL_4      = 2'h1;
    localparam logic [1:0]  PS_SEL_16     = 2'h2;
    localparam logic [5:0]  PS_LAST_1     = 6'h00;
    localparam logic [5:0]  PS_LAST_4     = 6'h03;
    localparam logic [5:0]  PS_LAST_16    = 6'h0F;
    localparam logic [5:0]  PS_LAST_64    = 6'h3F;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic       en;
        logic       oe;
        logic       pol;
    } ch_ctrl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [1:0] low;
    } duty_t;

    typedef struct packed {
        logic       run;
        logic [1:0] ps;
    } tctrl_t;

endpackage

`default_nettype wire

// file: sim/pin_load_model.sv
// Port pin multiplexer and pad load behind the PWM channel outputs
`timescale 1ns/100ps
`default_nettype none

module pin_load_model (
    input  wire logic                       clk_i,     // Clock
    input  wire logic [pwm_pkg::NUM_CH-1:0] level_i,   // Channel levels
    input  wire logic [pwm_pkg::NUM_CH-1:0] oe_i,      // Channel owns pin
    input  wire logic [pwm_pkg::NUM_CH-1:0] latch_i,   // Port data latch
    input  wire logic [pwm_pkg::NUM_CH-1:0] dir_out_i, // Pin is an output
    output logic      [pwm_pkg::NUM_CH-1:0] pad_o      // Pad levels
);
    // ========================================================
    // Floating pad
    // Changes every cycle so a stale level never looks valid
    logic float_reg = 1'b0;
    always @(posedge clk_i) begin
        float_reg <= ~float_reg;
    end

    // ========================================================
    // Pin multiplexer
    assign pad_o = (dir_out_i & ((oe_i & level_i) | (~oe_i & latch_i)))
                 | (~dir_out_i & {pwm_pkg::NUM_CH{float_reg}});
endmodule
`default_nettype wire

// file: sim/shared_period_pwm_channels_test.sv
// Self-checking bench of the shared-period PWM channels
`timescale 1ns/100ps
`default_nettype none

module shared_period_pwm_channels_test;
    // ========================================================
    // Signals
    localparam logic [7:0] CH0 = 8'h10;
    localparam logic [7:0] DHI = 8'h04;
    localparam logic [7:0] DLO = 8'h08;
    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] rst;
        logic [7:0] wdat;
        logic [7:0] exp;
    } row_t;
    row_t        rows [9] = '{
        '{8'h00, 8'hFF, 8'h5A, 8'h5A}, '{8'h04, 8'h00, 8'h01, 8'h01},
        '{8'h08, 8'h00, 8'h55, 8'h00}, '{8'h10, 8'h00, 8'hCF, 8'hC0},
        '{8'h20, 8'h00, 8'h9F, 8'hB0}, '{8'h14, 8'h00, 8'hA5, 8'hA5},
        '{8'h18, 8'h00, 8'hFF, 8'hC0}, '{8'hFC, 8'h00, 8'hFF, 8'h00},
        '{8'h40, 8'h00, 8'h10, 8'h30}};
    logic [7:0]  dh_v [3] = '{8'h00, 8'h00, 8'hFF};
    logic [7:0]  dl_v [3] = '{8'h80, 8'h00, 8'hC0};
    logic [7:0]  ctl_v [3] = '{8'hC0, 8'hD0, 8'hC0};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'hF;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        sleep = 1'b0;
    logic [3:0]  latch = 4'h0;
    logic [3:0]  dir_out = 4'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [3:0]  level;
    logic [3:0]  oe;
    logic [3:0]  pad;
    logic [3:0]  lv;
    logic [31:0] q;
    logic [31:0] q2;
    int          hits [4];
    int          n_fail = 0;
    int          comparisons = 0;
    int          k;
    int          p;

    always #25 clk = ~clk;

    shared_period_pwm_channels shared_period_pwm_channels_i (
        .clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat), .we_i(we),
        .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack),
        .sleep_i(sleep), .pin_level_o(level), .pin_oe_o(oe));

    pin_load_model pin_load_model_i (
        .clk_i(clk), .level_i(level), .oe_i(oe), .latch_i(latch),
        .dir_out_i(dir_out), .pad_o(pad));

    // ========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        @(posedge clk);
        adr <= a;
        we <= w;
        wdat <= {24'h000000, d};
        sel <= s;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(a, 1'b1, d, 4'hF, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        wb(a, 1'b0, 8'h00, 4'hF, r);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Counts high pad cycles of every channel over one window
    task automatic count_all(input int n);
        hits = '{0, 0, 0, 0};
        repeat (n) begin
            @(posedge clk);
            for (int c = 0; c < 4; c++) hits[c] += (pad[c] === 1'b1) ? 1 : 0;
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ========================================================
    // Watchdog
    initial begin
        #1000000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end

    // ========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            rd(rows[i].adr, q);
            check(q, {24'h000000, rows[i].rst});
            wr(rows[i].adr, rows[i].wdat);
            rd(rows[i].adr, q);
            check(q, {24'h000000, rows[i].exp});
        end
        // Pins held as inputs until the first period has passed
        dir_out <= 4'h0;
        wr(pwm_pkg::ADR_PERIOD, 8'h00);
        for (int c = 0; c < 3; c++) begin
            wr(8'((c + 1) * 16), 8'h00);
            wr(8'((c + 1) * 16) + DHI, dh_v[c]);
            wr(8'((c + 1) * 16) + DLO, dl_v[c]);
        end
        wr(pwm_pkg::ADR_TCTRL, 8'h04);
        idle(8);
        dir_out <= 4'hF;
        for (int c = 0; c < 3; c++) wr(8'((c + 1) * 16), ctl_v[c]);
        for (int ps = 0; ps < 4; ps++) begin
            p = 1 << (2 * ps);
            wr(pwm_pkg::ADR_TCTRL, 8'(4 + ps));
            idle(8 * p + 70);
            count_all(8 * p);
            check(32'(hits[0]), 32'(4 * p));
            check(32'(hits[1]), 32'(8 * p));
            check(32'(hits[2]), 32'(8 * p));
        end
        // New duty written just after a rollover must wait for the next one
        for (k = 0; k < 600 && pad[0] !== 1'b0; k++) @(posedge clk);
        for (k = 0; k < 600 && pad[0] !== 1'b1; k++) @(posedge clk);
        wr(CH0 + DLO, 8'h40);
        count_all(200);
        check(32'(hits[0] > 100), 32'h1);
        idle(100);
        count_all(512);
        check(32'(hits[0]), 32'd128);
        wr(pwm_pkg::ADR_TCTRL, 8'h04);
        wr(pwm_pkg::ADR_PERIOD, 8'h01);
        wr(CH0 + DHI, 8'h01);
        wr(CH0 + DLO, 8'h40);
        idle(100);
        count_all(16);
        check(32'(hits[0]), 32'd10);
        wr(pwm_pkg::ADR_PERIOD, 8'hFF);
        idle(20);
        sleep <= 1'b1;
        idle(2);
        rd(pwm_pkg::ADR_COUNT, q);
        lv = pad;
        idle(40);
        rd(pwm_pkg::ADR_COUNT, q2);
        check(q2, q);
        check({28'h0000000, pad}, {28'h0000000, lv});
        sleep <= 1'b0;
        idle(40);
        rd(pwm_pkg::ADR_COUNT, q2);
        check(32'(q2 !== q), 32'h1);
        wb(CH0, 1'b1, 8'h00, 4'hE, q);
        rd(CH0, q);
        check(q & 32'h000000C0, 32'h000000C0);
        latch <= 4'hF;
        wr(CH0, 8'h00);
        idle(3);
        check({31'h00000000, oe[0]}, 32'h0);
        check({31'h00000000, level[0]}, 32'h0);
        check({31'h00000000, pad[0]}, 32'h1);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        check({28'h0000000, oe}, 32'h0);
        rd(pwm_pkg::ADR_PERIOD, q);
        check(q, 32'h000000FF);
        rd(8'h30, q);
        check(q, 32'h00000000);
        final_report();
    end
endmodule
`default_nettype wire
